// ---- logic/rpd_pkg.sv ----
package rpd_pkg;
    // ----------------------------------------
    // Register offsets
    // ----------------------------------------
    localparam logic [7:0] OFF_PORT_SEL = 8'h4C;
    localparam logic [7:0] OFF_FV_MIN = 8'hBC;
    localparam logic [7:0] OFF_RSVD_BD = 8'hBD;
    localparam logic [7:0] OFF_PD_CTL = 8'hBE;
    localparam logic [7:0] OFF_RSVD_BF = 8'hBF;
    localparam logic [7:0] OFF_RSVD_C0 = 8'hC0;
    localparam logic [7:0] OFF_RSVD_CF = 8'hCF;
    localparam logic [7:0] OFF_PORT_DEBUG = 8'hD0;
    // ----------------------------------------
    // Reset values and fields
    // ----------------------------------------
    localparam logic [7:0] RST_FV_MIN = 8'h80;
    localparam logic [7:0] RST_PD_CTL = 8'h00;
    localparam logic [7:0] RST_RSVD = 8'h00;
    localparam logic [7:0] RST_PORT_SEL = 8'h00;
    localparam int BIT_ERR_ONCE = 0;
    localparam int BIT_ERR_CONT = 1;
    localparam int BIT_SELFTEST = 5;
    localparam int SEL_RD_LO = 4;
    localparam int NUM_PORTS = 4;
    localparam int NUM_PINS = 8;
endpackage : rpd_pkg

// ---- logic/rpd_bus_if.sv ----
`timescale 1ns/1ps
interface rpd_bus_if;
    logic wrEn;
    logic [7:0] addr;
    logic [7:0] wrData;
    logic [7:0] rdData;
    modport master (output wrEn, addr, wrData, input rdData);
    modport slave (input wrEn, addr, wrData, output rdData);
endinterface : rpd_bus_if

// ---- logic/rpd_fs_gate.sv ----
`timescale 1ns/1ps
module rpd_fs_gate
    import rpd_pkg::*;
(
    input wire logic sys_clk,
    input wire logic rst_n,
    input wire logic frameValid,
    input wire logic [7:0] minTime,
    output logic frameStart
);
    logic [7:0] count;
    logic fired;

    // ----------------------------------------
    // Duration count in receive clock periods
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            count <= 8'h00;
            fired <= 1'b0;
            frameStart <= 1'b0;
        end
        else if (!frameValid)
        begin
            count <= 8'h00;
            fired <= 1'b0;
            frameStart <= 1'b0;
        end
        else
        begin
            frameStart <= 1'b0;
            if (!fired && count >= minTime)
            begin
                fired <= 1'b1;
                frameStart <= 1'b1;
            end
            else if (count != 8'hFF)
                count <= count + 8'h01;
        end
    end

    property p_no_early;
        @(posedge sys_clk) disable iff (!rst_n)
        frameStart |-> $past(frameValid) && $past(count >= minTime);
    endproperty
    a_no_early: assert property (p_no_early) else $error("frame start too early");

    property p_one_pulse;
        @(posedge sys_clk) disable iff (!rst_n)
        frameStart |=> !frameStart;
    endproperty
    a_one_pulse: assert property (p_one_pulse) else $error("frame start longer than one cycle");
endmodule : rpd_fs_gate

// ---- logic/rpd_regs.sv ----
`timescale 1ns/1ps
// Notes on behaviour
// - Frame start is held back until frame valid has been high for the programmed minimum, reset 0x80.
// - The minimum is counted in receive clock periods.
// - Each pin's pull-down is on only while the pin is not an output.
// - A set pull-down disable bit also turns the pull-down off for an input pin; all bits reset to 0.
// - Port select uses bits 5:4 as binary read port and bits 3:0 as per-port write enables, any number of which can be set.
// - Paged debug accesses go to the copy of the port chosen by the port select.
// - Bit 5 of the debug register reads the remote self-test state of that port.
// - While bit 1 is set, back-channel frames of that port are corrupted continuously.
// - Writing 1 to bit 0 injects exactly one back-channel error, then the bit clears itself.
module rpd_regs
    import rpd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Register access
    input wire logic wrEn,
    input wire logic [7:0] addr,
    input wire logic [7:0] wrData,
    output logic [7:0] rdData,
    // Frame timing
    input wire logic frameValid,
    output logic frameStart,
    // Pins
    input wire logic [NUM_PINS-1:0] pinIsOutput,
    output logic [NUM_PINS-1:0] pulldownEnable,
    // Per-port link
    input wire logic [NUM_PORTS-1:0] remoteSelftestActive,
    input wire logic [NUM_PORTS-1:0] backchanFrameDone,
    output logic [NUM_PORTS-1:0] backchanCorrupt
);
    rpd_bus_if bus();
    logic [7:0] frameValidMinTime;
    logic [7:0] gpioPulldownControl;
    logic [7:0] rxPortSelect;
    logic [NUM_PORTS-1:0] errContinuous;
    logic [NUM_PORTS-1:0] errOnce;
    logic [NUM_PORTS-1:0] pendingOnce;
    logic [NUM_PORTS-1:0] stA;
    logic [NUM_PORTS-1:0] stB;
    logic [NUM_PORTS-1:0] stC;
    logic [NUM_PORTS-1:0] selftestSeen;
    logic fsPulse;
    logic [7:0] next_rdData;
    logic [1:0] rdPort;

    assign bus.wrEn = wrEn;
    assign bus.addr = addr;
    assign bus.wrData = wrData;
    assign rdPort = rxPortSelect[SEL_RD_LO+1:SEL_RD_LO];

    function automatic logic isReserved(input logic [7:0] a);
        isReserved = (a == OFF_RSVD_BD) || (a == OFF_RSVD_BF) || (a >= OFF_RSVD_C0 && a <= OFF_RSVD_CF);
    endfunction : isReserved

    // ----------------------------------------
    // Shared registers
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            frameValidMinTime <= RST_FV_MIN;
            gpioPulldownControl <= RST_PD_CTL;
            rxPortSelect <= RST_PORT_SEL;
        end
        else if (bus.wrEn)
        begin
            if (bus.addr == OFF_FV_MIN)
                frameValidMinTime <= bus.wrData;
            if (bus.addr == OFF_PD_CTL)
                gpioPulldownControl <= bus.wrData;
            if (bus.addr == OFF_PORT_SEL)
                rxPortSelect <= {2'b00, bus.wrData[5:0]};
        end
    end

    // ----------------------------------------
    // Pull-down control
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            pulldownEnable <= '0;
        else
            pulldownEnable <= ~pinIsOutput & ~gpioPulldownControl;
    end

    // ----------------------------------------
    // Per-port debug copies
    // ----------------------------------------
    for (genvar p = 0; p < NUM_PORTS; p++)
    begin : g_port
        logic wrHit;
        assign wrHit = bus.wrEn && bus.addr == OFF_PORT_DEBUG && rxPortSelect[p];

        always_ff @(posedge sys_clk or negedge rst_n)
        begin
            if (!rst_n)
            begin
                errContinuous[p] <= 1'b0;
                errOnce[p] <= 1'b0;
                pendingOnce[p] <= 1'b0;
            end
            else
            begin
                if (wrHit)
                    errContinuous[p] <= bus.wrData[BIT_ERR_CONT];
                errOnce[p] <= wrHit && bus.wrData[BIT_ERR_ONCE];
                if (wrHit && bus.wrData[BIT_ERR_ONCE])
                    pendingOnce[p] <= 1'b1;
                else if (backchanFrameDone[p])
                    pendingOnce[p] <= 1'b0;
            end
        end

        always_ff @(posedge sys_clk or negedge rst_n)
        begin
            if (!rst_n)
                backchanCorrupt[p] <= 1'b0;
            else
                backchanCorrupt[p] <= errContinuous[p] || pendingOnce[p];
        end
    end

    // ----------------------------------------
    // Self-test status synchroniser
    // ----------------------------------------
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            stA <= '0;
            stB <= '0;
            stC <= '0;
            selftestSeen <= '0;
        end
        else
        begin
            stA <= remoteSelftestActive;
            stB <= stA;
            stC <= stB;
            for (int i = 0; i < NUM_PORTS; i++)
                if (stB[i] == stC[i])
                    selftestSeen[i] <= stC[i];
        end
    end

    // ----------------------------------------
    // Read data
    // ----------------------------------------
    always_comb
    begin
        next_rdData = 8'h00;
        if (bus.addr == OFF_FV_MIN)
            next_rdData = frameValidMinTime;
        else if (bus.addr == OFF_PD_CTL)
            next_rdData = gpioPulldownControl;
        else if (bus.addr == OFF_PORT_SEL)
            next_rdData = rxPortSelect;
        else if (isReserved(bus.addr))
            next_rdData = RST_RSVD;
        else if (bus.addr == OFF_PORT_DEBUG)
        begin
            next_rdData[BIT_SELFTEST] = selftestSeen[rdPort];
            next_rdData[BIT_ERR_CONT] = errContinuous[rdPort];
            next_rdData[BIT_ERR_ONCE] = errOnce[rdPort];
        end
    end

    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
            bus.rdData <= 8'h00;
        else
            bus.rdData <= next_rdData;
    end
    assign rdData = bus.rdData;

    rpd_fs_gate u_fs_gate (
        .sys_clk(sys_clk),
        .rst_n(rst_n),
        .frameValid(frameValid),
        .minTime(frameValidMinTime),
        .frameStart(fsPulse)
    );
    assign frameStart = fsPulse;

    // ----------------------------------------
    // Checks
    // ----------------------------------------
    property p_pulldown;
        @(posedge sys_clk) disable iff (!rst_n)
        rst_n |=> pulldownEnable == $past(~pinIsOutput & ~gpioPulldownControl);
    endproperty
    a_pulldown: assert property (p_pulldown) else $error("pull-down wrong");

    property p_pd_out_off;
        @(posedge sys_clk) disable iff (!rst_n)
        pinIsOutput[0] |=> !pulldownEnable[0];
    endproperty
    a_pd_out_off: assert property (p_pd_out_off) else $error("pull-down on output");

    property p_once_clears;
        @(posedge sys_clk) disable iff (!rst_n)
        errOnce[0] && !(wrEn && addr == OFF_PORT_DEBUG && rxPortSelect[0] && wrData[BIT_ERR_ONCE])
            |=> !errOnce[0];
    endproperty
    a_once_clears: assert property (p_once_clears) else $error("once bit stuck");

    property p_once_inject;
        @(posedge sys_clk) disable iff (!rst_n)
        (wrEn && addr == OFF_PORT_DEBUG && rxPortSelect[0] && wrData[BIT_ERR_ONCE]) |-> ##2 backchanCorrupt[0];
    endproperty
    a_once_inject: assert property (p_once_inject) else $error("single error missing");

    property p_cont;
        @(posedge sys_clk) disable iff (!rst_n)
        errContinuous[1] |=> backchanCorrupt[1];
    endproperty
    a_cont: assert property (p_cont) else $error("continuous errors missing");

    property p_page_wr;
        @(posedge sys_clk) disable iff (!rst_n)
        (wrEn && addr == OFF_PORT_DEBUG && !rxPortSelect[2]) |=> $stable(errContinuous[2]);
    endproperty
    a_page_wr: assert property (p_page_wr) else $error("write hit wrong port");

    property p_rsvd;
        @(posedge sys_clk) disable iff (!rst_n)
        isReserved(addr) |=> rdData == RST_RSVD;
    endproperty
    a_rsvd: assert property (p_rsvd) else $error("reserved read wrong");

    property p_fvmin_rst;
        @(posedge sys_clk) disable iff (!rst_n)
        $rose(rst_n) |-> frameValidMinTime == RST_FV_MIN;
    endproperty
    a_fvmin_rst: assert property (p_fvmin_rst) else $error("minimum reset wrong");

    property p_short_pulse;
        @(posedge sys_clk) disable iff (!rst_n)
        !frameValid |=> !frameStart;
    endproperty
    a_short_pulse: assert property (p_short_pulse) else $error("frame start without frame valid");

    c_fs: cover property (@(posedge sys_clk) frameStart);
    c_once: cover property (@(posedge sys_clk) errOnce[0]);
    c_cont: cover property (@(posedge sys_clk) backchanCorrupt[3]);
endmodule : rpd_regs

// ---- tb/rpd_far_model.sv ----
`timescale 1ns/1ps
module rpd_far_model
    import rpd_pkg::*;
(
    // Clock and reset
    input wire logic sys_clk,
    input wire logic rst_n,
    // Bench commands
    input wire logic [NUM_PORTS-1:0] endFrame,
    input wire logic [NUM_PORTS-1:0] selftestReq,
    // Link side
    output logic [NUM_PORTS-1:0] backchanFrameDone,
    output logic [NUM_PORTS-1:0] remoteSelftestActive
);
    // Frame end pulses and remote self-test levels
    always_ff @(posedge sys_clk or negedge rst_n)
    begin
        if (!rst_n)
        begin
            backchanFrameDone <= '0;
            remoteSelftestActive <= '0;
        end
        else
        begin
            backchanFrameDone <= endFrame;
            remoteSelftestActive <= selftestReq;
        end
    end
endmodule : rpd_far_model

// ---- tb/test_rx_port_debug_misc_regs.sv ----
`timescale 1ns/1ps
module test_rx_port_debug_misc_regs;
    import rpd_pkg::*;
    logic sys_clk, rst_n, wrEn, frameValid, frameStart, rdReq, rdSeen;
    logic [7:0] addr, wrData, rdData, pinIsOutput, pulldownEnable, pdCtl, minT;
    logic [NUM_PORTS-1:0] endFrame, selftestReq, backchanFrameDone, remoteSelftestActive, backchanCorrupt;
    int failures, nChecks, fsCount, waitN;
    logic [7:0] expQ [$];
    logic [7:0] rsvA [5] = '{OFF_RSVD_BD, OFF_RSVD_BF, OFF_RSVD_C0, OFF_RSVD_CF, 8'h10};

    initial
    begin
        sys_clk = 1'b0;
        forever #12.5 sys_clk = ~sys_clk;
    end

    rpd_regs dut_u (.sys_clk(sys_clk), .rst_n(rst_n), .wrEn(wrEn), .addr(addr), .wrData(wrData),
        .rdData(rdData), .frameValid(frameValid), .frameStart(frameStart), .pinIsOutput(pinIsOutput),
        .pulldownEnable(pulldownEnable), .remoteSelftestActive(remoteSelftestActive),
        .backchanFrameDone(backchanFrameDone), .backchanCorrupt(backchanCorrupt));
    rpd_far_model far_u (.sys_clk(sys_clk), .rst_n(rst_n), .endFrame(endFrame), .selftestReq(selftestReq),
        .backchanFrameDone(backchanFrameDone), .remoteSelftestActive(remoteSelftestActive));

    task automatic check(string name, logic [7:0] seen, logic [7:0] exp);
        nChecks++;
        if (seen !== exp)
        begin
            failures++;
            $display("[FAIL] %s expected %h seen %h", name, exp, seen);
        end
    endtask : check

    task automatic wr(logic [7:0] a, logic [7:0] d);
        @(posedge sys_clk);
        wrEn <= 1'b1;
        addr <= a;
        wrData <= d;
        @(posedge sys_clk);
        wrEn <= 1'b0;
    endtask : wr

    // Read request notes its expectation
    task automatic rd(logic [7:0] a, logic [7:0] e);
        @(posedge sys_clk);
        addr <= a;
        rdReq <= 1'b1;
        expQ.push_back(e);
        @(posedge sys_clk);
        rdReq <= 1'b0;
    endtask : rd

    task automatic test_done();
        $display("checks %0d failures %0d", nChecks, failures);
        if (failures == 0 && nChecks > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : test_done

    // ----------------------------------------
    // Output monitors
    // ----------------------------------------
    always @(posedge sys_clk)
        rdSeen <= rdReq;
    always @(negedge sys_clk)
        if (rdSeen === 1'b1) check("rdData", rdData, expQ.pop_front());
    always @(posedge sys_clk)
        if (frameStart === 1'b1) fsCount++;

    initial
    begin
        #(5000 * 25);
        failures++;
        test_done();
    end

    initial
    begin
        rst_n = 1'b0; wrEn = 1'b0; addr = '0; wrData = '0; frameValid = 1'b0; rdReq = 1'b0; rdSeen = 1'b0;
        pinIsOutput = '0; endFrame = '0; selftestReq = '0; failures = 0; nChecks = 0; fsCount = 0;
        void'($urandom(32'h15EA));
        repeat (2) @(posedge sys_clk);
        rst_n <= 1'b1;
        // ----------------------------------------
        // Reset values, reserved and port select
        // ----------------------------------------
        rd(OFF_FV_MIN, RST_FV_MIN);
        rd(OFF_PD_CTL, RST_PD_CTL);
        rd(OFF_PORT_DEBUG, 8'h00);
        pdCtl = 8'($urandom);
        minT = 8'(4 + $urandom % 8);
        wr(OFF_PD_CTL, pdCtl);
        wr(OFF_FV_MIN, minT);
        foreach (rsvA[i])
        begin
            wr(rsvA[i], 8'hFF);
            rd(rsvA[i], RST_RSVD);
        end
        rd(OFF_PD_CTL, pdCtl);
        rd(OFF_FV_MIN, minT);
        wr(OFF_PORT_SEL, 8'hFF);
        rd(OFF_PORT_SEL, 8'h3F);
        // ----------------------------------------
        // Pull-downs
        // ----------------------------------------
        repeat (4)
        begin
            @(posedge sys_clk);
            pinIsOutput <= 8'($urandom);
            @(posedge sys_clk);
            @(negedge sys_clk);
            check("pulldownEnable", pulldownEnable, ~pinIsOutput & ~pdCtl);
        end
        // ----------------------------------------
        // Frame start gating
        // ----------------------------------------
        @(posedge sys_clk);
        frameValid <= 1'b1;
        repeat (minT - 2) @(posedge sys_clk);
        frameValid <= 1'b0;
        repeat (3) @(posedge sys_clk);
        check("fsShort", 8'(fsCount), 8'h00);
        frameValid <= 1'b1;
        waitN = 0;
        while (frameStart !== 1'b1 && waitN < 40)
        begin
            @(negedge sys_clk);
            waitN++;
        end
        check("fsDelay", 8'(waitN >= minT && waitN <= minT + 2), 8'h01);
        repeat (20) @(posedge sys_clk);
        frameValid <= 1'b0;
        @(posedge sys_clk);
        check("fsCount", 8'(fsCount), 8'h01);
        // ----------------------------------------
        // Paged debug, continuous errors
        // ----------------------------------------
        for (int p = 0; p < NUM_PORTS; p++)
        begin
            @(posedge sys_clk);
            selftestReq <= 4'(1 << p);
            wr(OFF_PORT_SEL, 8'((p << 4) | (1 << p)));
            wr(OFF_PORT_DEBUG, 8'h02);
            repeat (4) @(posedge sys_clk);
            rd(OFF_PORT_DEBUG, 8'h22);
            @(negedge sys_clk);
            check("corruptCont", 8'(backchanCorrupt), 8'(1 << p));
            wr(OFF_PORT_DEBUG, 8'h00);
        end
        // ----------------------------------------
        // Single error, self clearing
        // ----------------------------------------
        @(posedge sys_clk);
        selftestReq <= '0;
        wr(OFF_PORT_SEL, 8'h01);
        wr(OFF_PORT_DEBUG, 8'h01);
        repeat (2) @(posedge sys_clk);
        @(negedge sys_clk);
        check("corruptOnce", 8'(backchanCorrupt), 8'h01);
        rd(OFF_PORT_DEBUG, 8'h00);
        @(posedge sys_clk);
        endFrame <= 4'h1;
        @(posedge sys_clk);
        endFrame <= '0;
        repeat (3) @(posedge sys_clk);
        @(negedge sys_clk);
        check("corruptDone", 8'(backchanCorrupt), 8'h00);
        repeat (3) @(posedge sys_clk);
        test_done();
    end
endmodule : test_rx_port_debug_misc_regs
